// >>> dssr_pkg.sv
// Functional notes
// - Five read/write scratch words sit at byte offsets 0ACh to 0BCh.
// - Each scratch word is 32 bits and both bus sides may read and write it.
// - A value written from one side is returned to reads from the other.
// - Scratch accesses store or return data only and never raise an irq.
// - Reset clears every scratch word to all zeros.
// - Offsets 0C0h to 0FCh are reserved and hold no functional register.
package dssr_pkg;

  // ******************************************************************
  // Data path sizes
  // ******************************************************************
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 12;
  localparam int SCR_COUNT = 5;
  localparam int IDX_W = 3;
  localparam int WORD_LSB = 2;

  // ******************************************************************
  // Register map, byte addresses
  // ******************************************************************
  localparam logic [31:0] OFF_SHARED_SCRATCH_3 = 32'h0000_00ac;
  localparam logic [31:0] OFF_SHARED_SCRATCH_4 = 32'h0000_00b0;
  localparam logic [31:0] OFF_SHARED_SCRATCH_5 = 32'h0000_00b4;
  localparam logic [31:0] OFF_SHARED_SCRATCH_6 = 32'h0000_00b8;
  localparam logic [31:0] OFF_SHARED_SCRATCH_7 = 32'h0000_00bc;
  localparam logic [31:0] SCR_BASE = OFF_SHARED_SCRATCH_3;
  localparam logic [31:0] SCR_LAST = OFF_SHARED_SCRATCH_7;
  localparam logic [31:0] RSV_BASE = 32'h0000_00c0;
  localparam logic [31:0] RSV_LAST = 32'h0000_00fc;

  // ******************************************************************
  // Reset value and reserved read value
  // ******************************************************************
  localparam logic [DATA_W-1:0] SCR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RSV_READ = 32'h0000_0000;

endpackage

// >>> dssr_scratch.sv
`timescale 1ns/1ps
module dssr_scratch #(
  parameter int ADDR_W = dssr_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic priReq,
  input wire logic priWe,
  input wire logic [ADDR_W-1:0] priAddr,
  input wire logic [dssr_pkg::BE_W-1:0] priBe,
  input wire logic [dssr_pkg::DATA_W-1:0] priWdata,
  output logic priAck_q,
  output logic priHit_q,
  output logic [dssr_pkg::DATA_W-1:0] priRdata_q,
  input wire logic secReq,
  input wire logic secWe,
  input wire logic [ADDR_W-1:0] secAddr,
  input wire logic [dssr_pkg::BE_W-1:0] secBe,
  input wire logic [dssr_pkg::DATA_W-1:0] secWdata,
  output logic secAck_q,
  output logic secHit_q,
  output logic [dssr_pkg::DATA_W-1:0] secRdata_q
);

  localparam int DW = dssr_pkg::DATA_W;
  localparam int NR = dssr_pkg::SCR_COUNT;
  localparam int IW = dssr_pkg::IDX_W;

  // ******************************************************************
  // Elaboration check
  // ******************************************************************
  // The map reaches 0FCh, so fewer than eight address bits cannot decode it.
  if (ADDR_W < 8 || ADDR_W > 32) begin : gBadAddrW
    $error("dssr_scratch: ADDR_W must lie between 8 and 32.");
  end

  // Read view of all byte lane flops; each lane drives its own slice.
  wire logic [NR-1:0][DW-1:0] scratchWords;

  // ******************************************************************
  // Address decode, primary side
  // ******************************************************************
  // Address bits 1:0 are ignored; byte enables pick the lanes instead.
  wire logic [31:0] priAddr32 = 32'(priAddr);
  wire logic priScrHit = priAddr32 >= dssr_pkg::SCR_BASE &&
                         priAddr32 <= (dssr_pkg::SCR_LAST | 32'h3);
  wire logic priRsvHit = priAddr32 >= dssr_pkg::RSV_BASE &&
                         priAddr32 <= (dssr_pkg::RSV_LAST | 32'h3);
  wire logic [IW-1:0] priIdx =
    IW'((priAddr32 - dssr_pkg::SCR_BASE) >> dssr_pkg::WORD_LSB);
  wire logic priWrScr = priReq && priWe && priScrHit;
  wire logic priRdScr = priReq && !priWe && priScrHit;
  wire logic [DW-1:0] priRdSel =
    priRdScr ? scratchWords[priIdx] : dssr_pkg::RSV_READ;

  // ******************************************************************
  // Address decode, secondary side
  // ******************************************************************
  wire logic [31:0] secAddr32 = 32'(secAddr);
  wire logic secScrHit = secAddr32 >= dssr_pkg::SCR_BASE &&
                         secAddr32 <= (dssr_pkg::SCR_LAST | 32'h3);
  wire logic secRsvHit = secAddr32 >= dssr_pkg::RSV_BASE &&
                         secAddr32 <= (dssr_pkg::RSV_LAST | 32'h3);
  wire logic [IW-1:0] secIdx =
    IW'((secAddr32 - dssr_pkg::SCR_BASE) >> dssr_pkg::WORD_LSB);
  wire logic secWrScr = secReq && secWe && secScrHit;
  wire logic secRdScr = secReq && !secWe && secScrHit;
  wire logic [DW-1:0] secRdSel =
    secRdScr ? scratchWords[secIdx] : dssr_pkg::RSV_READ;

  // ******************************************************************
  // Scratch storage
  // ******************************************************************
  // Each byte lane of each word picks its source on its own. When both sides
  // write the same lane in one cycle the primary side wins; software that
  // shares a word is expected to own it by convention, so no arbitration
  // beyond this fixed order is worth its area.
  for (genvar r = 0; r < NR; r++) begin : gReg
    for (genvar b = 0; b < dssr_pkg::BE_W; b++) begin : gLane
      wire logic priLaneWr = priWrScr && priIdx == IW'(r) && priBe[b];
      wire logic secLaneWr = secWrScr && secIdx == IW'(r) && secBe[b];
      localparam int LO = b * dssr_pkg::BYTE_W;
      logic [dssr_pkg::BYTE_W-1:0] lane_q;
      wire logic [dssr_pkg::BYTE_W-1:0] lane_d =
        priLaneWr ? priWdata[LO +: dssr_pkg::BYTE_W] :
        secLaneWr ? secWdata[LO +: dssr_pkg::BYTE_W] :
        lane_q;

      // Lane register; reset clears it, otherwise it keeps the last write.
      // Each lane owns its flop, so no two processes share one variable.
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          lane_q <= dssr_pkg::SCR_RESET[LO +: dssr_pkg::BYTE_W];
        end else begin
          lane_q <= lane_d;
        end
      end

      // Publish the lane into the shared read view.
      assign scratchWords[r][LO +: dssr_pkg::BYTE_W] = lane_q;
    end
  end

  // ******************************************************************
  // Answer registers
  // ******************************************************************
  // Every request is answered one cycle later; read data is the word as it
  // stood before any write in the same cycle. Nothing here feeds an irq.
  wire logic [DW-1:0] priRdataD = priRdSel;
  wire logic [DW-1:0] secRdataD = secRdSel;

  // Primary answer flops.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      priAck_q <= 1'b0;
      priHit_q <= 1'b0;
      priRdata_q <= dssr_pkg::SCR_RESET;
    end else begin
      priAck_q <= priReq;
      priHit_q <= priReq && (priScrHit || priRsvHit);
      priRdata_q <= priRdataD;
    end
  end

  // Secondary answer flops.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secAck_q <= 1'b0;
      secHit_q <= 1'b0;
      secRdata_q <= dssr_pkg::SCR_RESET;
    end else begin
      secAck_q <= secReq;
      secHit_q <= secReq && (secScrHit || secRsvHit);
      secRdata_q <= secRdataD;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  wire logic anyScrWr = priWrScr || secWrScr;

  // A full-word write from the secondary side, then a primary read of it.
  sequence sSecFullWrite;
    secWrScr && secBe == '1 && !(priWrScr && priIdx == secIdx);
  endsequence

  sequence sPriReadSame;
    priRdScr && priIdx == $past(secIdx) && !anyScrWr;
  endsequence

  a_reset_clears_all: assert property (
    @(posedge core_clk) !rst_n |=> scratchWords == '0 && !priAck_q &&
    !secAck_q && !priHit_q && !secHit_q)
    else $error("Scratch words not cleared by reset.");

  a_pri_answer_time: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priReq |=> priAck_q ##1 (priAck_q == $past(priReq)))
    else $error("Primary answer not one cycle after request.");

  a_pri_read_data: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priRdScr |=> priRdata_q == $past(scratchWords[priIdx]) && priHit_q)
    else $error("Primary read returned the wrong word.");

  a_cross_side_pass: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sSecFullWrite ##1 sPriReadSame |=> priRdata_q == $past(secWdata, 2))
    else $error("Secondary write not seen by primary read.");

  a_sec_write_store: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sSecFullWrite |=> scratchWords[$past(secIdx)] == $past(secWdata))
    else $error("Secondary full write not stored.");

  a_reserved_reads_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    secReq && !secWe && secRsvHit |=> secRdata_q == '0 && secHit_q)
    else $error("Reserved read did not return zero.");

  a_reserved_write_drop: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (priReq && priWe && priRsvHit && !secWrScr) |=> $stable(scratchWords))
    else $error("Reserved write changed a scratch word.");

  a_no_side_effect: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rst_n && !anyScrWr) [*2] |-> $stable(scratchWords))
    else $error("Scratch changed without a write.");

  // Other-side mirrors of most checks above; the reserved write drop and the
  // unmapped check below are made on the primary side only.
  sequence sPriFullWrite;
    priWrScr && priBe == '1;
  endsequence

  sequence sSecReadSame;
    secRdScr && secIdx == $past(priIdx) && !anyScrWr;
  endsequence

  a_sec_answer_time: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    secReq |=> secAck_q ##1 (secAck_q == $past(secReq)))
    else $error("Secondary answer not one cycle after request.");

  a_sec_read_data: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    secRdScr |=> secRdata_q == $past(scratchWords[secIdx]) && secHit_q)
    else $error("Secondary read returned the wrong word.");

  // The primary side wins lane collisions, so no exclusion is needed here.
  a_pri_write_store: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sPriFullWrite |=> scratchWords[$past(priIdx)] == $past(priWdata))
    else $error("Primary full write not stored.");

  a_pri_to_sec: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sPriFullWrite ##1 sSecReadSame |=> secRdata_q == $past(priWdata, 2))
    else $error("Primary write not seen by secondary read.");

  // A write answer carries no data, so nothing can leak out of a write.
  a_pri_write_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priReq && priWe |=> priRdata_q == '0 && priAck_q)
    else $error("Primary write answer carried data.");

  a_sec_write_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    secReq && secWe |=> secRdata_q == '0 && secAck_q)
    else $error("Secondary write answer carried data.");

  a_pri_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priReq && !priWe && priRsvHit |=> priRdata_q == '0 && priHit_q)
    else $error("Primary reserved read did not return zero.");

  // Addresses outside the decoded map answer, but claim no hit.
  a_unmapped_no_hit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priReq && !priScrHit && !priRsvHit |=> !priHit_q && priRdata_q == '0)
    else $error("Unmapped access claimed a hit or returned data.");

endmodule

// >>> dssr_agent.sv
`timescale 1ns/1ps
// Bus agent of one side; lines wander while idle so stale data never helps.
module dssr_agent (
  input wire logic core_clk,
  output logic req,
  output logic we,
  output logic [11:0] addr,
  output logic [3:0] be,
  output logic [31:0] wdata,
  input wire logic ack,
  input wire logic hit,
  input wire logic [31:0] rdata
);
  initial begin
    req = 1'b0;
    {we, addr, be, wdata} = '0;
  end
  // One single-cycle request, answer sampled once the ack edge has settled.
  task automatic access(input logic w, input logic [11:0] a,
    input logic [3:0] b, input logic [31:0] d,
    output logic [31:0] rd, output logic h, output logic k);
    @(posedge core_clk);
    req <= 1'b1;
    {we, addr, be, wdata} <= {w, a, b, d};
    @(posedge core_clk);
    req <= 1'b0;
    {we, addr, wdata} <= {~w, ~a, ~d};
    #1;
    {rd, h, k} = {rdata, hit, ack};
  endtask
endmodule

// >>> test_dual_side_scratch_registers.sv
`timescale 1ns/1ps
module test_dual_side_scratch_registers;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pReq, pWe, pAck, pHit, sReq, sWe, sAck, sHit;
  logic [11:0] pAddr, sAddr;
  logic [3:0] pBe, sBe;
  logic [31:0] pWd, pRd, sWd, sRd, r, rd, rb;
  logic [31:0] model [5];
  int badCount = 0;
  int numChecks = 0;
  int cycles = 0;
  int idx;
  // ******************************************************************
  // Clock, agents and design
  // ******************************************************************
  initial forever #2 core_clk = ~core_clk;
  dssr_agent i_pri (.core_clk(core_clk), .req(pReq), .we(pWe), .addr(pAddr),
    .be(pBe), .wdata(pWd), .ack(pAck), .hit(pHit), .rdata(pRd));
  dssr_agent i_sec (.core_clk(core_clk), .req(sReq), .we(sWe), .addr(sAddr),
    .be(sBe), .wdata(sWd), .ack(sAck), .hit(sHit), .rdata(sRd));
  dssr_scratch i_dut (.core_clk(core_clk), .rst_n(rst_n), .priReq(pReq),
    .priWe(pWe), .priAddr(pAddr), .priBe(pBe), .priWdata(pWd),
    .priAck_q(pAck), .priHit_q(pHit), .priRdata_q(pRd), .secReq(sReq),
    .secWe(sWe), .secAddr(sAddr), .secBe(sBe), .secWdata(sWd),
    .secAck_q(sAck), .secHit_q(sHit), .secRdata_q(sRd));
  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Every access must be answered next cycle, with hit over 0ACh to 0FFh.
  task automatic xfer(input bit s, input logic w, input logic [11:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    logic h, k;
    if (s) i_sec.access(w, a, b, d, q, h, k);
    else i_pri.access(w, a, b, d, q, h, k);
    check({31'h0, k}, 32'h1);
    check({31'h0, h}, {31'h0, a >= 12'h0ac && a <= 12'h0ff});
    if (w) check(q, 32'h0);
  endtask
  // Both sides must see the model value in every scratch word.
  task automatic read_all(input string tag);
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 2; s++) begin
        xfer(s[0], 1'b0, 12'(12'h0ac + 4 * i), 4'hf, 32'h0, rd);
        check(rd, model[i]);
      end
    end
    $display("test %s done", tag);
  endtask
  // ******************************************************************
  // Timeout and main sequence
  // ******************************************************************
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      report_and_stop();
    end
  end
  initial begin
    r = 32'h2d;
    foreach (model[i]) model[i] = 32'h0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    read_all("reset");
    // Random writes from one side, read back from the other side.
    for (int n = 0; n < 40; n++) begin
      r = lfsr(r);
      idx = int'(r[15:8]) % 5;
      xfer(r[0], 1'b1, 12'(12'h0ac + 4 * idx), r[7:4], r ^ 32'h5a3c, rd);
      for (int l = 0; l < 4; l++) begin
        if (r[4 + l]) model[idx][8 * l +: 8] = 8'((r ^ 32'h5a3c) >> (8 * l));
      end
      xfer(~r[0], 1'b0, 12'(12'h0ac + 4 * idx), 4'hf, 32'h0, rd);
      check(rd, model[idx]);
    end
    $display("test crossing done");
    // Full write on one side, read of it on the other in the next cycle.
    for (int n = 0; n < 12; n++) begin
      r = lfsr(r);
      idx = int'(r[11:8]) % 5;
      model[idx] = r;
      fork
        xfer(r[0], 1'b1, 12'(12'h0ac + 4 * idx), 4'hf, r, rd);
        begin
          @(posedge core_clk);
          xfer(~r[0], 1'b0, 12'(12'h0ac + 4 * idx), 4'hf, 32'h0, rb);
        end
      join
      check(rb, model[idx]);
    end
    $display("test back to back done");
    // Reserved words swallow writes and read as zero.
    for (int a = 12'h0c0; a <= 12'h0fc; a += 4) begin
      r = lfsr(r);
      xfer(r[0], 1'b1, 12'(a), 4'hf, r, rd);
      xfer(~r[0], 1'b0, 12'(a), 4'hf, 32'h0, rd);
      check(rd, 32'h0);
    end
    // Unmapped words next to the map claim no hit and read as zero.
    for (int u = 0; u < 2; u++) begin
      r = lfsr(r);
      xfer(r[0], 1'b1, u ? 12'h100 : 12'h0a8, 4'hf, r, rd);
      xfer(~r[0], 1'b0, u ? 12'h100 : 12'h0a8, 4'hf, 32'h0, rd);
      check(rd, 32'h0);
    end
    read_all("reserved");
    // A reset in mid-run clears every word again.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (model[i]) model[i] = 32'h0;
    read_all("second reset");
    report_and_stop();
  end
endmodule
